// ---- bus_steer.sv ----
// Purpose: steers core data transfers onto a shared or a split memory bus
// Assumes: bus pins and test clock are asynchronous, passed through two flops
// Notes: writes are buffered in a 32-word fifo drained one word per bus cycle
//
// Summary of operation
// - a static select pin chooses shared bus or split read/write buses
// - select low: transfers on shared bus, split write bus held at zero
// - select low: split read bus ignored; system ties it low
// - select high: split buses used, shared bus input ignored
// - shared bus driven in every cycle except read cycles while output enable is high
// - write data on shared bus held past the end of the cycle
// - write data appears only while output enable is high
// - output enable low puts the shared bus in high impedance
// - output enable low suppresses data on the split write bus
// - bus disable high when internal test selected on chain 0, 4 or 8
// - bus disable changes only after a test clock falling edge
// - split read bus sampled during read cycles at the sample point
// - split write bus data valid from the cycle after the write cycle
`timescale 1ns/1ps

// ==========================================================
// fifo with valid/ready on both sides
module bus_steer_fifo
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
)
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   // fill side
   input wire logic i_valid,
   input wire logic [WIDTH-1:0] i_data,
   output logic o_ready,
   // drain side
   output logic o_valid,
   output logic [WIDTH-1:0] o_data,
   input wire logic i_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [CW-1:0] count_q;
   logic push;
   logic pop;

   // handshake flags
   assign o_ready = count_q != CW'(DEPTH);
   assign o_valid = count_q != '0;
   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;
   assign o_data = mem[rd_ptr_q];

   // storage array
   always_ff @(posedge i_ref_clk)
   begin
      if (push)
         mem[wr_ptr_q] <= i_data;
   end

   // pointers and fill count
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         if (pop)
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         if (push && !pop)
            count_q <= count_q + 1'b1;
         else if (pop && !push)
            count_q <= count_q - 1'b1;
      end
   end
endmodule

// ==========================================================
// bus steering top
module bus_steer
   import bus_steer_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   // core write stream
   input wire logic i_wr_valid,
   input wire logic [DATA_W-1:0] i_wr_data,
   output logic o_wr_ready,
   // core read request and answer
   input wire logic i_rd_req,
   output logic o_rd_ready,
   output logic o_rd_valid,
   output logic [DATA_W-1:0] o_rd_data,
   // configuration pins
   input wire logic i_data_bus_select,
   input wire logic i_data_output_enable,
   // shared bidirectional bus
   input wire logic [DATA_W-1:0] i_shared_in,
   output logic [DATA_W-1:0] o_shared_out,
   output logic o_shared_oe,
   // split buses
   input wire logic [DATA_W-1:0] i_sep_rd_data,
   output logic [DATA_W-1:0] o_sep_wr_data,
   // cycle type
   output logic o_bus_read,
   output logic o_bus_write,
   // scan test
   input wire logic i_tck,
   input wire logic i_scan_intest,
   input wire logic [CHAIN_W-1:0] i_scan_chain,
   output logic o_scan_bus_disable
);
   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} bus_state_t;
   localparam int PIN_W = 2 * DATA_W + CHAIN_W + 4;

   bus_state_t state_q;
   logic [PIN_W-1:0] pin_s1_q;
   logic [PIN_W-1:0] pin_s2_q;
   logic tck_s;
   logic tck_d_q;
   logic intest_s;
   logic [CHAIN_W-1:0] chain_s;
   logic select_s;
   logic enable_s;
   logic [DATA_W-1:0] sep_rd_s;
   logic [DATA_W-1:0] shared_s;
   logic tck_fall;
   logic [RD_LAT-1:0] rd_pipe_q;
   logic [DATA_W-1:0] wr_data_q;
   logic [DATA_W-1:0] sep_wr_q;
   logic [DATA_W-1:0] rd_data_q;
   logic rd_valid_q;
   logic scan_dis_q;
   logic fifo_valid;
   logic [DATA_W-1:0] fifo_data;
   logic rd_start;
   logic wr_start;

   // true for scan chains that isolate the data bus
   function automatic logic bus_chain(input logic [CHAIN_W-1:0] chain);
      bus_chain = (chain == CHAIN_CORE) || (chain == CHAIN_ICE) || (chain == CHAIN_ALT);
   endfunction

   // ==========================================================
   // two-flop synchroniser on every pin input
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
      begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end
      else
      begin
         pin_s1_q <= {i_tck, i_scan_intest, i_scan_chain, i_data_bus_select,
                      i_data_output_enable, i_sep_rd_data, i_shared_in};
         pin_s2_q <= pin_s1_q;
      end
   end

   // unpack synchronised pins
   assign {tck_s, intest_s, chain_s, select_s, enable_s, sep_rd_s, shared_s} = pin_s2_q;

   // ==========================================================
   // write buffer between core and bus
   bus_steer_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_wr_fifo
   (
      .i_ref_clk(i_ref_clk),
      .i_rstn(i_rstn),
      .i_valid(i_wr_valid),
      .i_data(i_wr_data),
      .o_ready(o_wr_ready),
      .o_valid(fifo_valid),
      .o_data(fifo_data),
      .i_ready(wr_start)
   );

   // ==========================================================
   // cycle arbitration: reads first, writes only while enabled
   assign o_rd_ready = state_q == ST_IDLE;
   assign rd_start = i_rd_req && o_rd_ready;
   assign wr_start = (state_q == ST_IDLE) && !i_rd_req && fifo_valid && enable_s;
   assign o_bus_read = state_q == ST_READ;
   assign o_bus_write = state_q == ST_WRITE;

   // bus cycle state
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
         state_q <= ST_IDLE;
      else
      begin
         case (state_q)
            ST_IDLE:
               if (rd_start)
                  state_q <= ST_READ;
               else if (wr_start)
                  state_q <= ST_WRITE;
            ST_READ: state_q <= ST_IDLE;
            ST_WRITE: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // write data held until the next write loads it
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
         wr_data_q <= DATA_RST;
      else if (wr_start)
         wr_data_q <= fifo_data;
   end

   // split write bus zero unless selected and enabled
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
         sep_wr_q <= DATA_RST;
      else if (select_s && enable_s)
         sep_wr_q <= wr_data_q;
      else
         sep_wr_q <= DATA_RST;
   end

   // shared bus driven except in read cycles, released when disabled
   assign o_shared_oe = enable_s && (state_q != ST_READ);
   assign o_shared_out = wr_data_q;
   assign o_sep_wr_data = sep_wr_q;

   // ==========================================================
   // read sample point follows synchroniser latency
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
         rd_pipe_q <= RD_PIPE_RST;
      else
         rd_pipe_q <= {rd_pipe_q[RD_LAT-2:0], o_bus_read};
   end

   // read data taken from the selected bus only
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
      begin
         rd_data_q <= DATA_RST;
         rd_valid_q <= 1'b0;
      end
      else
      begin
         rd_valid_q <= rd_pipe_q[RD_LAT-1];
         if (rd_pipe_q[RD_LAT-1])
            rd_data_q <= select_s ? sep_rd_s : shared_s;
      end
   end

   assign o_rd_valid = rd_valid_q;
   assign o_rd_data = rd_data_q;

   // ==========================================================
   // bus disable updated on synchronised test clock falling edge
   assign tck_fall = tck_d_q && !tck_s;

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
      begin
         tck_d_q <= 1'b0;
         scan_dis_q <= SCAN_DIS_RST;
      end
      else
      begin
         tck_d_q <= tck_s;
         if (tck_fall)
            scan_dis_q <= intest_s && bus_chain(chain_s);
      end
   end

   assign o_scan_bus_disable = scan_dis_q;

   // ==========================================================
   // checks
   property p_sel_low_wr_zero;
      @(posedge i_ref_clk) disable iff (!i_rstn) !select_s |=> o_sep_wr_data == '0;
   endproperty
   a_sel_low_wr_zero: assert property (p_sel_low_wr_zero) else $error("split bus not 0");

   property p_en_low_wr_zero;
      @(posedge i_ref_clk) disable iff (!i_rstn) !enable_s |=> o_sep_wr_data == '0;
   endproperty
   a_en_low_wr_zero: assert property (p_en_low_wr_zero) else $error("write not blocked");

   property p_en_low_hiz;
      @(posedge i_ref_clk) disable iff (!i_rstn) !enable_s |-> !o_shared_oe && !wr_start;
   endproperty
   a_en_low_hiz: assert property (p_en_low_hiz) else $error("shared bus driven when off");

   property p_drive_not_read;
      @(posedge i_ref_clk) disable iff (!i_rstn) enable_s && !o_bus_read |-> o_shared_oe;
   endproperty
   a_drive_not_read: assert property (p_drive_not_read) else $error("shared bus floats");

   property p_wr_held;
      @(posedge i_ref_clk) disable iff (!i_rstn) o_bus_write ##1 !o_bus_write |-> $stable(o_shared_out);
   endproperty
   a_wr_held: assert property (p_wr_held) else $error("write data not held");

   property p_rd_shared;
      @(posedge i_ref_clk) disable iff (!i_rstn)
         o_bus_read ##1 !select_s ##1 !select_s |=> o_rd_valid && o_rd_data == $past(shared_s);
   endproperty
   a_rd_shared: assert property (p_rd_shared) else $error("shared read data wrong");

   property p_rd_split;
      @(posedge i_ref_clk) disable iff (!i_rstn)
         o_bus_read ##1 select_s ##1 select_s |=> o_rd_valid && o_rd_data == $past(sep_rd_s);
   endproperty
   a_rd_split: assert property (p_rd_split) else $error("split read data wrong");

   property p_scan_dis_value;
      @(posedge i_ref_clk) disable iff (!i_rstn)
         tck_fall |=> o_scan_bus_disable == $past(intest_s && bus_chain(chain_s));
   endproperty
   a_scan_dis_value: assert property (p_scan_dis_value) else $error("bus disable wrong");

   property p_scan_dis_edge;
      @(posedge i_ref_clk) disable iff (!i_rstn) !tck_fall |=> $stable(o_scan_bus_disable);
   endproperty
   a_scan_dis_edge: assert property (p_scan_dis_edge) else $error("bus disable moved");

   // main scenarios
   c_read: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) o_rd_valid);
   c_wr_split: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) o_bus_write && select_s);
   c_fifo_full: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) !o_wr_ready);
   c_scan_dis: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) o_scan_bus_disable);
endmodule

// ---- bus_steer_pkg.sv ----
// Purpose: shared constants for the core data bus steering block
// Assumes: single 125 MHz core clock, synchronous active-low reset
// Notes: chain numbers are those on which internal test isolates the data bus
package bus_steer_pkg;
   // ==========================================================
   // widths and depths
   localparam int DATA_W = 32;
   localparam int FIFO_DEPTH = 32;
   localparam int CHAIN_W = 4;
   // ==========================================================
   // scan chains that raise the bus disable output
   localparam logic [3:0] CHAIN_CORE = 4'h0;
   localparam logic [3:0] CHAIN_ICE = 4'h4;
   localparam logic [3:0] CHAIN_ALT = 4'h8;
   // ==========================================================
   // reset values
   localparam logic [31:0] DATA_RST = 32'h0000_0000;
   localparam logic [1:0] RD_PIPE_RST = 2'h0;
   localparam logic SCAN_DIS_RST = 1'b0;
   // cycles from end of read cycle to synchronised bus data
   localparam int RD_LAT = 2;
endpackage

// ---- mem_model.sv ----
// Purpose: far-side memory system for the bus steering block
// Assumes: read word is held stable by the bench through each read
// Notes: an undriven shared bus shows a pattern that flips every cycle
`timescale 1ns/1ps

// ==========================================================
// memory system model
module mem_model
   import bus_steer_pkg::*;
(
   // clock
   input wire logic i_ref_clk,
   // pins seen from the block
   input wire logic i_data_bus_select,
   input wire logic i_shared_oe,
   input wire logic [DATA_W-1:0] i_shared_out,
   input wire logic i_scan_bus_disable,
   // word the memory returns
   input wire logic [DATA_W-1:0] i_word,
   // pins driven toward the block
   output logic [DATA_W-1:0] o_shared_in,
   output logic [DATA_W-1:0] o_sep_rd_data
);
   logic [DATA_W-1:0] last_q;

   // last level of the shared wire
   always_ff @(posedge i_ref_clk)
   begin
      last_q <= o_shared_in;
   end

   // wire levels from all drivers
   always_comb
   begin
      if (i_shared_oe)
         o_shared_in = i_shared_out;
      else if (!i_data_bus_select && !i_scan_bus_disable)
         o_shared_in = i_word;
      else
         o_shared_in = ~last_q;
      o_sep_rd_data = i_data_bus_select ? i_word : DATA_RST;
   end
endmodule

// ---- testbench.sv ----
// Purpose: self-checking bench for the bus steering block
// Assumes: 125 MHz core clock, sync active-low reset
// Notes: write and read results are checked from queues by a watcher
`timescale 1ns/1ps

// ==========================================================
// bench top
module testbench;
   import bus_steer_pkg::*;
   logic i_ref_clk, i_rstn, i_wr_valid, i_rd_req, sel, ena, i_tck, i_scan_intest;
   logic [DATA_W-1:0] i_wr_data, word, sh_in, sep_rd, sh_out, sep_wr, rd_data;
   logic [CHAIN_W-1:0] i_scan_chain;
   logic wr_ready, rd_ready, rd_valid, sh_oe, bus_rd, bus_wr, bus_dis, wr_seen, dis_held;
   logic [DATA_W-1:0] wr_q[$], rd_q[$], exp_w;
   logic [31:0] seed;
   int failures, n_compared;

   bus_steer u_dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_wr_valid(i_wr_valid),
      .i_wr_data(i_wr_data), .o_wr_ready(wr_ready), .i_rd_req(i_rd_req),
      .o_rd_ready(rd_ready), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
      .i_data_bus_select(sel), .i_data_output_enable(ena), .i_shared_in(sh_in),
      .o_shared_out(sh_out), .o_shared_oe(sh_oe), .i_sep_rd_data(sep_rd),
      .o_sep_wr_data(sep_wr), .o_bus_read(bus_rd), .o_bus_write(bus_wr),
      .i_tck(i_tck), .i_scan_intest(i_scan_intest), .i_scan_chain(i_scan_chain),
      .o_scan_bus_disable(bus_dis));
   mem_model u_mem (.i_ref_clk(i_ref_clk), .i_data_bus_select(sel), .i_shared_oe(sh_oe),
      .i_shared_out(sh_out), .i_word(word), .i_scan_bus_disable(bus_dis), .o_shared_in(sh_in),
      .o_sep_rd_data(sep_rd));

   // clock
   initial
   begin
      i_ref_clk = 1'b0;
      forever #4 i_ref_clk = ~i_ref_clk;
   end

   // ==========================================================
   // helpers
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic check(input string name, input logic [DATA_W-1:0] exp, got);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // core write, taken when ready is seen at an edge
   task automatic wr(input logic [DATA_W-1:0] d);
      @(posedge i_ref_clk);
      i_wr_valid <= 1'b1;
      i_wr_data <= d;
      do @(posedge i_ref_clk); while (wr_ready !== 1'b1);
      wr_q.push_back(d);
      i_wr_valid <= 1'b0;
   endtask

   // core read, memory word held until the answer
   task automatic rd(input logic [DATA_W-1:0] d);
      @(posedge i_ref_clk);
      i_rd_req <= 1'b1;
      word <= d;
      do @(posedge i_ref_clk); while (rd_ready !== 1'b1);
      rd_q.push_back(d);
      i_rd_req <= 1'b0;
      repeat (6) @(posedge i_ref_clk);
   endtask

   task automatic pins(input logic s, e);
      @(posedge i_ref_clk);
      sel <= s;
      ena <= e;
      repeat (5) @(posedge i_ref_clk);
   endtask

   task automatic drain();
      for (int k = 0; k < 400 && wr_q.size() > 0; k++)
         @(posedge i_ref_clk);
      check("write queue left", 0, wr_q.size());
      repeat (3) @(posedge i_ref_clk);
   endtask

   task automatic traffic();
      for (int k = 0; k < 6; k++)
      begin
         wr(rnd());
         if (k % 2 == 1)
            rd(rnd());
      end
      drain();
      check("shared oe idle", 1, sh_oe);
   endtask

   // ==========================================================
   // watcher: outputs against the oldest notes
   always @(posedge i_ref_clk)
   begin
      if (wr_seen === 1'b1)
         check("split write bus", sel ? exp_w : DATA_RST, sep_wr);
      wr_seen <= 1'b0;
      if (bus_wr === 1'b1)
      begin
         exp_w = wr_q.pop_front();
         check("shared out", exp_w, sh_out);
         check("shared oe write", 1, sh_oe);
         wr_seen <= 1'b1;
      end
      if (bus_rd === 1'b1)
         check("shared oe read", 0, sh_oe);
      if (rd_valid === 1'b1)
         check("read data", rd_q.pop_front(), rd_data);
   end

   // watchdog
   initial
   begin
      repeat (20000) @(posedge i_ref_clk);
      failures++;
      end_of_test();
   end

   // ==========================================================
   // main sequence
   initial
   begin
      seed = 32'hb99e_d5c0;
      {i_rstn, i_wr_valid, i_rd_req, sel, ena, i_tck, i_scan_intest} = 7'h02;
      i_wr_data = DATA_RST;
      word = DATA_RST;
      i_scan_chain = 4'h0;
      failures = 0;
      n_compared = 0;
      repeat (3) @(posedge i_ref_clk);
      i_rstn <= 1'b1;
      pins(1'b0, 1'b1);
      traffic();
      $display("shared bus test done");
      pins(1'b1, 1'b1);
      traffic();
      $display("split bus test done");
      pins(1'b1, 1'b0);
      check("shared oe disabled", 0, sh_oe);
      for (int k = 0; k < FIFO_DEPTH; k++)
         wr(rnd());
      repeat (2) @(posedge i_ref_clk);
      check("fifo full ready", 0, wr_ready);
      check("split bus disabled", DATA_RST, sep_wr);
      pins(1'b1, 1'b1);
      drain();
      $display("output enable test done");
      for (int ch = 0; ch < 16; ch++)
         for (int it = 0; it < 2; it++)
         begin
            @(posedge i_ref_clk);
            i_tck <= 1'b1;
            repeat (4) @(posedge i_ref_clk);
            dis_held = bus_dis;
            i_scan_intest <= it[0];
            i_scan_chain <= ch[CHAIN_W-1:0];
            repeat (5) @(posedge i_ref_clk);
            check("bus disable held", dis_held, bus_dis);
            i_tck <= 1'b0;
            repeat (7) @(posedge i_ref_clk);
            check("bus disable", it == 1 && ch inside {0, 4, 8}, bus_dis);
         end
      $display("scan test done");
      end_of_test();
   end
endmodule
